// ===== src/fscp_core.sv
/*
  Framed serial command interpreter: takes 12-byte command frames from a
  byte stream, checks and decodes them, and shifts out 12-byte replies.
  Also latches operating errors and gates the pulse output.
  Assumes rx bytes and all inputs are synchronous to clk; the host waits
  for a reply before sending the next frame.
*/
//
// Behaviour
// [RL1] Frame is 12 consecutive bytes, else discarded
// [RL2] Command then parameter, most significant first
// [RL3] Byte eleven reserved zero, byte twelve checksum
// [RL4] Checksum is XOR of first eleven bytes
// [RL5] Every good frame gets a 12-byte reply
// [RL6] Host resends when no reply arrives
// [RL7] Bad parameter answered with 0xFF12, zero
// [RL8] Unknown command answered with 0xFF13, zero
// [RL9] Broken frame answered 0xFF11, host resends
// [RL10] Broken after four repeats answered 0xFF10
// [RL11] Presence query answered 0xFF01, no side effect
// [RL12] Identification query returns device identification value
// [RL13] Hardware version in three lowest bytes
// [RL14] Software version in three lowest bytes
// [RL15] Serial query: length or character at position
// [RL16] Name query: length or character at position
// [RL17] Operating error stops pulses, status shows error
// [RL18] Only enable toggle clears error, pulses stay off; code resumes pulses once the error clears while pulse_req is high
// [RL19] Error cause readable raw and as text
// [RL20] Inter-byte timeout configurable, restarts at byte one
module fscp_core
  import fscp_pkg::*;
#(
  parameter int          TIMEOUT_CYC = TIMEOUT_DEF,
  parameter logic [63:0] DEVICE_ID   = 64'h0000_0000_0000_5A5A, // Arbitrary value
  parameter logic [23:0] HW_VERSION  = 24'h01_00_00,
  parameter logic [23:0] SW_VERSION  = 24'h01_00_00,
  parameter int          SERIAL_LEN  = 4,
  parameter logic [31:0] SERIAL_TEXT = 32'h3030_3031,
  parameter int          NAME_LEN    = 4,
  parameter logic [31:0] NAME_TEXT   = 32'h4653_4350
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       error_event,
  input  wire logic [7:0] error_code,
  input  wire logic       ext_enable,
  input  wire logic       pulse_req,
  output logic            pulse_out,
  output logic [1:0]      status_code,
  output logic            error_latched
);

  localparam logic [15:0] TMO_LAST = 16'(TIMEOUT_CYC - 1);

  fscp_regs_type s_q;
  fscp_regs_type s_d;
  logic [15:0]   dec_cmd;
  logic [63:0]   dec_par;
  logic [15:0]   rx_cmd;
  logic [63:0]   rx_par;
  logic          frame_end;
  logic          frame_good;

  function automatic logic [95:0] make_frame(input logic [15:0] c, input logic [63:0] p);
    logic [95:0] f;
    logic [7:0]  x;
    f = {c, p, RSV_BYTE, 8'h00};
    x = 8'h00;
    for (int i = 0; i < FRAME_BYTES - 1; i++) begin
      x = x ^ f[95 - 8*i -: 8]; // [RL4]
    end
    f[7:0] = x;
    return f;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] pick_char(input logic [31:0] txt, input int len,
                                           input logic [63:0] pos);
    logic [31:0] sh;
    sh = txt >> (8 * (len - int'(pos[7:0])));
    return sh[7:0];
  endfunction

  // Bytes 1..11 sit in rx_buf when the checksum byte arrives
  assign rx_cmd     = s_q.rx_buf[87:72]; // [RL2]
  assign rx_par     = s_q.rx_buf[71:8]; // [RL2]
  assign frame_end  = rx_valid && s_q.st == ST_RX && s_q.idx == LAST_IDX;
  assign frame_good = frame_end && rx_data == s_q.acc
                      && s_q.rx_buf[7:0] == RSV_BYTE; // [RL3] [RL4]

  // Reply to a good frame; queries only read state
  always_comb begin
    dec_cmd = REP_BAD_PAR; // [RL7]
    dec_par = 64'h0;
    case (rx_cmd)
      CMD_PING: begin
        if (rx_par == 64'h0) begin
          dec_cmd = REP_PING; // [RL11]
        end
      end
      CMD_IDENT: begin
        if (rx_par == 64'h0) begin
          dec_cmd = REP_IDENT; // [RL12]
          dec_par = DEVICE_ID;
        end
      end
      CMD_HWVER: begin
        if (rx_par == 64'h0) begin
          dec_cmd = REP_HWVER; // [RL13]
          dec_par = {40'h0, HW_VERSION};
        end
      end
      CMD_SWVER: begin
        if (rx_par == 64'h0) begin
          dec_cmd = REP_SWVER; // [RL14]
          dec_par = {40'h0, SW_VERSION};
        end
      end
      CMD_SERIAL: begin
        if (rx_par == 64'h0) begin
          dec_cmd = REP_SERIAL; // [RL15]
          dec_par = 64'(SERIAL_LEN);
        end else if (rx_par <= 64'(SERIAL_LEN)) begin
          dec_cmd = REP_SERIAL; // [RL15]
          dec_par = {56'h0, pick_char(SERIAL_TEXT, SERIAL_LEN, rx_par)};
        end
      end
      CMD_NAME: begin
        if (rx_par == 64'h0) begin
          dec_cmd = REP_NAME; // [RL16]
          dec_par = 64'(NAME_LEN);
        end else if (rx_par <= 64'(NAME_LEN)) begin
          dec_cmd = REP_NAME; // [RL16]
          dec_par = {56'h0, pick_char(NAME_TEXT, NAME_LEN, rx_par)};
        end
      end
      CMD_ERR_RAW: begin
        if (rx_par == 64'h0) begin
          dec_cmd = REP_ERR_RAW; // [RL19]
          dec_par = {56'h0, s_q.cause};
        end
      end
      CMD_ERR_TXT: begin
        dec_cmd = REP_ERR_TXT; // [RL19]
        if (rx_par == 64'h0) begin
          dec_par = ERR_TXT_LEN;
        end else if (rx_par == 64'h1) begin
          dec_par = {56'h0, hex_char(s_q.cause[7:4])};
        end else if (rx_par == ERR_TXT_LEN) begin
          dec_par = {56'h0, hex_char(s_q.cause[3:0])};
        end else begin
          dec_cmd = REP_BAD_PAR; // [RL7]
        end
      end
      default: begin
        dec_cmd = REP_UNKNOWN; // [RL8]
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      ST_RX: begin
        if (rx_valid) begin
          s_d.rx_buf = {s_q.rx_buf[79:0], rx_data};
          s_d.acc    = s_q.acc ^ rx_data;
          s_d.idx    = s_q.idx + 4'h1;
          s_d.tmo    = '0;
          if (s_q.idx == LAST_IDX) begin
            s_d.idx    = '0;
            s_d.acc    = '0;
            s_d.st     = ST_TX;
            s_d.tx_act = 1'b1;
            s_d.tx_idx = '0;
            if (frame_good) begin
              s_d.retry  = '0;
              s_d.tx_buf = make_frame(dec_cmd, dec_par); // [RL5]
            end else if (s_q.retry == MAX_REPEATS) begin
              s_d.retry  = '0;
              s_d.tx_buf = make_frame(REP_FAIL, 64'h0); // [RL10]
            end else begin
              s_d.retry  = s_q.retry + 3'h1; // [RL10]
              s_d.tx_buf = make_frame(REP_REPEAT, 64'h0); // [RL9]
            end
          end
        end else if (s_q.idx != 4'h0) begin
          s_d.tmo = s_q.tmo + 16'h1;
          if (s_q.tmo == TMO_LAST) begin
            s_d.idx = '0; // [RL1] [RL20]
            s_d.acc = '0;
            s_d.tmo = '0;
          end
        end
      end
      ST_TX: begin
        // Bytes arriving while replying are dropped; host waits for the reply
        if (tx_ready) begin
          s_d.tx_buf = {s_q.tx_buf[87:0], 8'h00};
          s_d.tx_idx = s_q.tx_idx + 4'h1;
          if (s_q.tx_idx == LAST_IDX) begin
            s_d.tx_act = 1'b0; // [RL5]
            s_d.st     = ST_RX;
          end
        end
      end
      default: begin
        s_d.st = ST_RX;
      end
    endcase
    s_d.en_prev = ext_enable;
    if (error_event) begin
      s_d.err   = 1'b1; // [RL17]
      s_d.cause = error_code; // [RL19]
    end else if (ext_enable != s_q.en_prev) begin
      s_d.err = 1'b0; // [RL18]
    end
    s_d.pulse = pulse_req && !s_d.err; // [RL17] [RL18]
    s_d.stat  = {s_d.err, s_d.pulse}; // [RL17]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= REGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_valid      = s_q.tx_act;
  assign tx_data       = s_q.tx_buf[95:88];
  assign pulse_out     = s_q.pulse;
  assign status_code   = s_q.stat;
  assign error_latched = s_q.err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence broken_end;
    frame_end && !frame_good;
  endsequence

  sequence reply_start;
    $rose(s_q.tx_act);
  endsequence

  reply_len_a: assert property ( // [RL5]
    reply_start ##0 tx_ready [*8] ##1 tx_ready [*4] |=> !tx_valid)
    else $error("reply frame not exactly 12 bytes");

  reply_sum_a: assert property ( // [RL4]
    reply_start |-> (^{s_q.tx_buf[95:8]} == ^s_q.tx_buf[7:0])
      && (s_q.tx_buf[95:88] ^ s_q.tx_buf[87:80] ^ s_q.tx_buf[79:72]
      ^ s_q.tx_buf[71:64] ^ s_q.tx_buf[63:56] ^ s_q.tx_buf[55:48]
      ^ s_q.tx_buf[47:40] ^ s_q.tx_buf[39:32] ^ s_q.tx_buf[31:24]
      ^ s_q.tx_buf[23:16] ^ s_q.tx_buf[15:8]) == s_q.tx_buf[7:0]
      && s_q.tx_buf[15:8] == RSV_BYTE)
    else $error("reply checksum or reserved byte wrong");

  repeat_req_a: assert property ( // [RL9]
    broken_end ##0 s_q.retry != MAX_REPEATS |=>
      s_q.tx_buf[95:80] == REP_REPEAT && s_q.tx_buf[79:16] == 64'h0)
    else $error("broken frame not answered with repeat request");

  fail_reply_a: assert property ( // [RL10]
    broken_end ##0 s_q.retry == MAX_REPEATS |=>
      s_q.tx_buf[95:80] == REP_FAIL && s_q.retry == 3'h0)
    else $error("fifth broken frame not answered with failure");

  ping_reply_a: assert property ( // [RL11]
    frame_good && rx_cmd == CMD_PING && rx_par == 64'h0 |=>
      s_q.tx_buf[95:80] == REP_PING && s_q.tx_buf[79:16] == 64'h0)
    else $error("presence query answered wrongly");

  unknown_cmd_a: assert property ( // [RL8]
    frame_good && rx_cmd[15:8] == 8'h12 |=>
      s_q.tx_buf[95:80] == REP_UNKNOWN && s_q.tx_buf[79:16] == 64'h0)
    else $error("unknown command not answered as unknown");

  byte_timeout_a: assert property ( // [RL20]
    s_q.st == ST_RX && s_q.idx != 4'h0 && !rx_valid && s_q.tmo == TMO_LAST
      |=> s_q.idx == 4'h0 && s_q.acc == 8'h00)
    else $error("partial frame survived inter-byte timeout");

  // An enable toggle right after the error may clear it, so look one cycle only
  error_stop_a: assert property ( // [RL17]
    error_event |=> !pulse_out && status_code == 2'b10 && error_latched)
    else $error("error did not stop pulses");

  error_hold_a: assert property ( // [RL18]
    error_latched && ext_enable == s_q.en_prev |=> error_latched && !pulse_out)
    else $error("error cleared without enable toggle");

  enable_clear_a: assert property ( // [RL18]
    error_latched && !error_event && ext_enable != s_q.en_prev |=>
      !error_latched)
    else $error("enable toggle did not clear the error");

  error_cause_a: assert property ( // [RL19]
    error_event |=>
      s_q.cause == $past(error_code))
    else $error("error cause not recorded");

  bad_param_a: assert property ( // [RL7]
    frame_good && rx_cmd == CMD_PING && rx_par != 64'h0 |=>
      s_q.tx_buf[95:80] == REP_BAD_PAR && s_q.tx_buf[79:16] == 64'h0)
    else $error("bad parameter not refused");

  ident_reply_a: assert property ( // [RL12]
    frame_good && rx_cmd == CMD_IDENT && rx_par == 64'h0 |=>
      s_q.tx_buf[95:80] == REP_IDENT && s_q.tx_buf[79:16] == DEVICE_ID)
    else $error("identification query answered wrongly");

  hw_version_a: assert property ( // [RL13]
    frame_good && rx_cmd == CMD_HWVER && rx_par == 64'h0 |=>
      s_q.tx_buf[95:80] == REP_HWVER && s_q.tx_buf[79:16] == {40'h0, HW_VERSION})
    else $error("hardware version answered wrongly");

  sw_version_a: assert property ( // [RL14]
    frame_good && rx_cmd == CMD_SWVER && rx_par == 64'h0 |=>
      s_q.tx_buf[95:80] == REP_SWVER && s_q.tx_buf[79:16] == {40'h0, SW_VERSION})
    else $error("software version answered wrongly");

  serial_len_a: assert property ( // [RL15]
    frame_good && rx_cmd == CMD_SERIAL && rx_par == 64'h0 |=>
      s_q.tx_buf[95:80] == REP_SERIAL && s_q.tx_buf[79:16] == 64'(SERIAL_LEN))
    else $error("serial length answered wrongly");

  name_len_a: assert property ( // [RL16]
    frame_good && rx_cmd == CMD_NAME && rx_par == 64'h0 |=>
      s_q.tx_buf[95:80] == REP_NAME && s_q.tx_buf[79:16] == 64'(NAME_LEN))
    else $error("name length answered wrongly");

  // Host may stall; the offered byte must wait for it
  reply_hold_a: assert property ( // [RL5]
    tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data))
    else $error("reply byte changed before it was taken");

endmodule

// ===== src/fscp_pkg.sv
/*
  Constants, state type and state record of the framed serial command block.
  Assumes one clock domain; fscp_core and tb_top import the whole package.
*/
package fscp_pkg;
  localparam int            FRAME_BYTES = 12;
  localparam logic [3:0]    LAST_IDX    = 4'hB;
  localparam logic [7:0]    RSV_BYTE    = 8'h00;
  localparam logic [2:0]    MAX_REPEATS = 3'h4;
  localparam int            TIMEOUT_DEF = 1000;
  localparam logic [15:0]   CMD_PING    = 16'hFE01;
  localparam logic [15:0]   CMD_IDENT   = 16'hFE02;
  localparam logic [15:0]   CMD_HWVER   = 16'hFE06;
  localparam logic [15:0]   CMD_SWVER   = 16'hFE07;
  localparam logic [15:0]   CMD_SERIAL  = 16'hFE08;
  localparam logic [15:0]   CMD_NAME    = 16'hFE09;
  localparam logic [15:0]   CMD_ERR_RAW = 16'h0020;
  localparam logic [15:0]   CMD_ERR_TXT = 16'h0021;
  localparam logic [15:0]   REP_PING    = 16'hFF01;
  localparam logic [15:0]   REP_IDENT   = 16'hFF02;
  localparam logic [15:0]   REP_HWVER   = 16'hFF06;
  localparam logic [15:0]   REP_SWVER   = 16'hFF07;
  localparam logic [15:0]   REP_SERIAL  = 16'hFF08;
  localparam logic [15:0]   REP_NAME    = 16'hFF09;
  localparam logic [15:0]   REP_ERR_RAW = 16'h0120;
  localparam logic [15:0]   REP_ERR_TXT = 16'h0121;
  localparam logic [15:0]   REP_FAIL    = 16'hFF10;
  localparam logic [15:0]   REP_REPEAT  = 16'hFF11;
  localparam logic [15:0]   REP_BAD_PAR = 16'hFF12;
  localparam logic [15:0]   REP_UNKNOWN = 16'hFF13;
  localparam logic [63:0]   ERR_TXT_LEN = 64'h2;

  typedef enum logic {ST_RX, ST_TX} fscp_state_type;

  typedef struct packed {
    fscp_state_type st;
    logic [3:0]     idx;
    logic [15:0]    tmo;
    logic [87:0]    rx_buf;
    logic [7:0]     acc;
    logic [2:0]     retry;
    logic [95:0]    tx_buf;
    logic [3:0]     tx_idx;
    logic           tx_act;
    logic           err;
    logic [7:0]     cause;
    logic           en_prev;
    logic           pulse;
    logic [1:0]     stat;
  } fscp_regs_type;

  localparam fscp_regs_type REGS_RESET = '0;
endpackage

// ===== verification/fscp_host.sv
/*
  Host model for the framed serial command block: sends command frames
  byte by byte and collects 12-byte replies, promptly or with stalls.
  Assumes the block's clock and that the bench calls its tasks.
*/
module fscp_host (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Frame of n bytes; flip corrupts the checksum on purpose
  task automatic send(input logic [15:0] c, input logic [63:0] p, input logic [7:0] r,
                      input logic [7:0] flip, input int n);
    logic [95:0] f;
    logic [7:0]  x;
    f = {c, p, r, 8'h00};
    x = 8'h00;
    for (int i = 0; i < 11; i++) x ^= f[95-8*i -: 8];
    f[7:0] = x ^ flip;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data  = f[95-8*i -: 8];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data; // Stale byte must not look valid
  endtask

  // No reply within the wait counts as a broken reply
  task automatic receive(input int stall, output logic [15:0] c, output logic [63:0] p,
                         output logic ok);
    logic [95:0] f;
    logic [7:0]  x;
    int          w;
    ok = 1'b1;
    f  = '1;
    for (int i = 0; i < 12; i++) begin
      w = 0;
      while (tx_valid !== 1'b1 && w < 200) begin
        @(negedge clk);
        w++;
      end
      if (w >= 200) ok = 1'b0;
      if (stall > 0) begin
        tx_ready = 1'b0; // Hold off the next byte for a while
        repeat (stall) @(negedge clk);
      end
      tx_ready = 1'b1;
      f[95-8*i -: 8] = tx_data;
      @(negedge clk);
    end
    tx_ready = 1'b0;
    x = 8'h00;
    for (int i = 0; i < 11; i++) x ^= f[95-8*i -: 8];
    if (x !== f[7:0] || f[15:8] !== 8'h00) ok = 1'b0;
    c = f[95:80];
    p = f[79:16];
  endtask
endmodule

// ===== verification/tb_top.sv
/*
  Self-checking bench for the framed serial command block: queries,
  error replies, broken frames, byte timeout and error latching.
  Assumes fscp_host as the far side and a 20-cycle byte timeout.
*/
`define FSCP_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import fscp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rst_n;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_ready;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       error_event;
  logic [7:0] error_code;
  logic       ext_enable;
  logic       pulse_req;
  logic       pulse_out;
  logic [1:0] status_code;
  logic       error_latched;
  int         bad_count;
  int         tests_run;
  int         cyc;

  fscp_core #(.TIMEOUT_CYC(20), .DEVICE_ID(64'h1234), // Arbitrary identity
    .HW_VERSION(24'h01_02_03), .SW_VERSION(24'h02_03_04)) dut_u (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .error_event(error_event), .error_code(error_code), .ext_enable(ext_enable),
    .pulse_req(pulse_req), .pulse_out(pulse_out), .status_code(status_code),
    .error_latched(error_latched));

  fscp_host host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 50000) begin
        bad_count++;
        test_done();
      end
    end
  end

  task automatic xfer(input logic [15:0] c, input logic [63:0] p, input logic [7:0] r,
    input logic [7:0] fl, input int st, input logic [15:0] ec, input logic [63:0] ep);
    logic [15:0] gc;
    logic [63:0] gp;
    logic        ok;
    host_u.send(c, p, r, fl, 12);
    host_u.receive(st, gc, gp, ok);
    `FSCP_CHK("reply_frame", 1'b1, ok)
    `FSCP_CHK("reply_cmd", ec, gc)
    `FSCP_CHK("reply_param", ep, gp)
  endtask

  task automatic t_queries();
    xfer(CMD_PING, 64'h0, 8'h00, 8'h00, 0, 16'hFF01, 64'h0);
    xfer(CMD_IDENT, 64'h0, 8'h00, 8'h00, 2, 16'hFF02, 64'h1234);
    xfer(CMD_HWVER, 64'h0, 8'h00, 8'h00, 0, 16'hFF06, 64'h010203);
    xfer(CMD_SWVER, 64'h0, 8'h00, 8'h00, 1, 16'hFF07, 64'h020304);
    xfer(CMD_SERIAL, 64'h0, 8'h00, 8'h00, 0, 16'hFF08, 64'h4);
    xfer(CMD_SERIAL, 64'h4, 8'h00, 8'h00, 0, 16'hFF08, 64'h31);
    xfer(CMD_NAME, 64'h0, 8'h00, 8'h00, 0, 16'hFF09, 64'h4);
    xfer(CMD_NAME, 64'h1, 8'h00, 8'h00, 3, 16'hFF09, 64'h46);
  endtask

  task automatic t_refusals();
    xfer(CMD_PING, 64'h1, 8'h00, 8'h00, 0, 16'hFF12, 64'h0);
    xfer(CMD_SERIAL, 64'h5, 8'h00, 8'h00, 0, 16'hFF12, 64'h0);
    xfer(16'h1234, 64'h0, 8'h00, 8'h00, 0, 16'hFF13, 64'h0);
  endtask

  // Four repeats are asked for, the fifth broken frame gives up
  task automatic t_broken();
    for (int i = 0; i < 4; i++) xfer(CMD_PING, 64'h0, 8'h00, 8'h01, 0, 16'hFF11, 64'h0);
    xfer(CMD_PING, 64'h0, 8'h00, 8'h01, 0, 16'hFF10, 64'h0);
    xfer(CMD_PING, 64'h0, 8'h00, 8'h00, 0, 16'hFF01, 64'h0);
    xfer(CMD_PING, 64'h0, 8'h55, 8'h00, 0, 16'hFF11, 64'h0);
    xfer(CMD_PING, 64'h0, 8'h00, 8'h00, 0, 16'hFF01, 64'h0);
  endtask

  // A stranded partial frame gets no reply; the resent frame must not shift
  task automatic t_timeout();
    host_u.send(CMD_IDENT, 64'h0, 8'h00, 8'h00, 5);
    repeat (30) @(negedge clk);
    `FSCP_CHK("tx_valid", 1'b0, tx_valid)
    xfer(CMD_IDENT, 64'h0, 8'h00, 8'h00, 0, 16'hFF02, 64'h1234);
  endtask

  task automatic t_fault();
    pulse_req = 1'b1;
    repeat (2) @(negedge clk);
    `FSCP_CHK("pulse_out", 1'b1, pulse_out)
    `FSCP_CHK("status", 2'b01, status_code)
    error_code  = 8'h5C;
    error_event = 1'b1;
    @(negedge clk);
    error_event = 1'b0;
    @(negedge clk);
    `FSCP_CHK("pulse_out", 1'b0, pulse_out)
    `FSCP_CHK("status", 2'b10, status_code)
    xfer(CMD_ERR_RAW, 64'h0, 8'h00, 8'h00, 0, REP_ERR_RAW, 64'h5C);
    xfer(CMD_ERR_TXT, 64'h1, 8'h00, 8'h00, 0, REP_ERR_TXT, 64'h35);
    xfer(CMD_ERR_TXT, 64'h2, 8'h00, 8'h00, 0, REP_ERR_TXT, 64'h43);
    xfer(CMD_PING, 64'h0, 8'h00, 8'h00, 0, 16'hFF01, 64'h0);
    `FSCP_CHK("error_latched", 1'b1, error_latched)
    `FSCP_CHK("pulse_out", 1'b0, pulse_out)
    ext_enable = ~ext_enable;
    repeat (3) @(negedge clk);
    `FSCP_CHK("error_latched", 1'b0, error_latched)
    `FSCP_CHK("pulse_out", 1'b1, pulse_out)
    `FSCP_CHK("status", 2'b01, status_code)
  endtask

  initial begin
    bad_count   = 0;
    tests_run   = 0;
    rst_n       = 1'b0;
    error_event = 1'b0;
    error_code  = 8'h00;
    ext_enable  = 1'b0;
    pulse_req   = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_queries();
    t_refusals();
    t_broken();
    t_timeout();
    t_fault();
    test_done();
  end
endmodule
